/* File: common/seea_pkg.sv */
// constants and types of the serial eeprom access engine
// assumes a 100 MHz system clock; nothing else is shared
`default_nettype none
package seea_pkg;
  localparam logic [3:0] DEV_TYPE = 4'ha;
  localparam int ADDR_W = 11;
  localparam int DATA_W = 8;
  localparam int BUF_W = ADDR_W + DATA_W;
  localparam int FIFO_DEPTH = 8;
  localparam int BUF_SLOTS = 16;
  localparam int BIT_LAST = 8;
  localparam int SMALL_PAGE_BITS = 3;
  localparam int LARGE_PAGE_BITS = 4;
  localparam int DENS_1K = 0;
  localparam int DENS_2K = 1;
  localparam int DENS_4K = 2;
  localparam int DENS_8K = 3;
  localparam int DENS_16K = 4;
  localparam int SMALLEST_SIZE = 128;
  localparam int CLK_PERIOD_NS = 10;
  localparam int T_WR_NS = 5000000;
  localparam int PROG_CYCLES = T_WR_NS / CLK_PERIOD_NS;
  typedef enum logic [3:0] {
    ST_IDLE = 4'h0,
    ST_DEVADR = 4'h1,
    ST_ADR_ACK = 4'h2,
    ST_WORD = 4'h3,
    ST_WORD_ACK = 4'h4,
    ST_WDATA = 4'h5,
    ST_WDATA_ACK = 4'h6,
    ST_RDATA = 4'h7,
    ST_RD_ACK = 4'h8,
    ST_RD_LOAD = 4'h9,
    ST_PROG = 4'ha
  } seea_state_t;
endpackage
`default_nettype wire

/* File: common/seea_stream_if.sv */
// valid/ready stream between the engine and its write fifo
// assumes both ends sit on the same clock
`timescale 1ns/1ps
`default_nettype none
interface seea_stream_if #(parameter int W = 19);
  logic valid;
  logic ready;
  logic [W-1:0] data;
  modport src(output valid, output data, input ready);
  modport snk(input valid, input data, output ready);
endinterface
`default_nettype wire

/* File: design/seea_fifo.sv */
// small flop fifo with valid/ready on both sides
// assumes DEPTH is a power of two
`timescale 1ns/1ps
`default_nettype none
module seea_fifo #(
  parameter int W = 19,
  parameter int DEPTH = 8
) (
  input wire logic clk_i,        // system clock
  input wire logic sys_rst_i,    // async reset, active high
  seea_stream_if.snk in_s,       // filling side
  seea_stream_if.src out_s       // draining side
);
  localparam int AW = $clog2(DEPTH);
  logic [W-1:0] mem_q [DEPTH];
  logic [AW:0] wr_ptr_q;
  logic [AW:0] rd_ptr_q;
  logic full;
  logic empty;

  // extra pointer bit tells full from empty
  assign full = (wr_ptr_q ^ rd_ptr_q) == {1'b1, {AW{1'b0}}};
  assign empty = wr_ptr_q == rd_ptr_q;
  assign in_s.ready = !full;
  assign out_s.valid = !empty;
  assign out_s.data = mem_q[rd_ptr_q[AW-1:0]];

  always_ff @(posedge clk_i) begin
    if (in_s.valid && !full) begin
      mem_q[wr_ptr_q[AW-1:0]] <= in_s.data;
    end
  end

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
    end else begin
      if (in_s.valid && !full) begin
        wr_ptr_q <= wr_ptr_q + 1'b1;
      end
      if (out_s.ready && !empty) begin
        rd_ptr_q <= rd_ptr_q + 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

/* File: design/seea_engine.sv */
// two-wire serial eeprom command engine, target side
// assumes scl/sda and straps are asynchronous pins; the array outside
// returns read data one clock after mem_raddr_o and takes writes on ready
// What this block does
// - acknowledge word address byte after device address
// - acknowledge data byte; stop launches programming
// - ignore bus and stay silent while programming
// - page buffer holds 8 or 16 bytes
// - acknowledge every page write data byte
// - only low page bits of address increment
// - in-page address wraps, later bytes overwrite earlier
// - polling address acknowledged only after programming
// - read direction bit set to one
// - address counter holds last address plus one
// - read address wraps from last to first
// - current read sends byte at counter
// - acknowledge read address then send addressed byte
// - host acknowledge advances to next read byte
// - eighth device address bit selects direction
// - mismatched device address gets no acknowledge
// - device address page bits extend word address
// - start and stop detected while clock high
`timescale 1ns/1ps
`default_nettype none
module seea_engine #(
  parameter int DENSITY = seea_pkg::DENS_16K,
  parameter int PROG_CYCLES = seea_pkg::PROG_CYCLES
) (
  input wire logic clk_i,                 // 100 MHz system clock
  input wire logic sys_rst_i,             // async reset, active high
  input wire logic scl_i,                 // bus clock pin
  input wire logic sda_i,                 // bus data pin level
  output logic sda_o,                     // bus data drive value, always low
  output logic sda_oe_o,                  // high while pulling data low
  input wire logic strap_select_high_i,   // address strap, top bit
  input wire logic strap_select_mid_i,    // address strap, middle bit
  input wire logic strap_select_low_i,    // address strap, low bit
  output logic [10:0] mem_raddr_o,        // array read address
  input wire logic [7:0] mem_rdata_i,     // array read data
  output logic [10:0] mem_waddr_o,        // array write address
  output logic [7:0] mem_wdata_o,         // array write data
  output logic mem_we_o,                  // array write request
  input wire logic mem_wready_i,          // array accepts write
  output logic busy_o                     // programming cycle running
);
  localparam int PG_BITS = (DENSITY <= seea_pkg::DENS_2K) ?
      seea_pkg::SMALL_PAGE_BITS : seea_pkg::LARGE_PAGE_BITS;
  localparam logic [10:0] ADDR_MASK = 11'((seea_pkg::SMALLEST_SIZE << DENSITY) - 1);
  localparam logic [10:0] PG_MASK = 11'((1 << PG_BITS) - 1);
  localparam logic [2:0] STRAP_MASK = (DENSITY <= seea_pkg::DENS_2K) ? 3'h7 :
      (DENSITY == seea_pkg::DENS_4K) ? 3'h6 :
      (DENSITY == seea_pkg::DENS_8K) ? 3'h4 : 3'h0;
  localparam logic [31:0] PROG_LAST = 32'(PROG_CYCLES - 1);
  localparam logic [3:0] CNT_LAST = 4'(seea_pkg::BIT_LAST);
  localparam logic [4:0] IDX_END = 5'(seea_pkg::BUF_SLOTS);

  seea_pkg::seea_state_t state_q;
  logic [1:0] scl_sq;
  logic [1:0] sda_sq;
  logic [2:0] strap_s0_q;
  logic [2:0] strap_q;
  logic scl_prev_q;
  logic sda_prev_q;
  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;
  logic [3:0] cnt_q;
  logic [7:0] shreg_q;
  logic rw_q;
  logic sda_oe_q;
  logic [2:0] page_bits_q;
  logic [10:0] addr_q;
  logic [10:0] row_q;
  logic data_seen_q;
  logic [7:0] buf_q [seea_pkg::BUF_SLOTS];
  logic [seea_pkg::BUF_SLOTS-1:0] buf_vld_q;
  logic [4:0] prog_idx_q;
  logic [31:0] prog_cnt_q;
  logic byte_done;
  logic dev_match;
  logic in_prog;
  logic prog_done;
  logic [3:0] widx;

  seea_stream_if #(.W(seea_pkg::BUF_W)) wr_in ();
  seea_stream_if #(.W(seea_pkg::BUF_W)) wr_out ();

  // straps are pins too, so they are synchronised like the bus
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      scl_sq <= 2'h3;
      sda_sq <= 2'h3;
      scl_prev_q <= 1'b1;
      sda_prev_q <= 1'b1;
      strap_s0_q <= 3'h0;
      strap_q <= 3'h0;
    end else begin
      scl_sq <= {scl_sq[0], scl_i};
      sda_sq <= {sda_sq[0], sda_i};
      scl_prev_q <= scl_sq[1];
      sda_prev_q <= sda_sq[1];
      strap_s0_q <= {strap_select_high_i, strap_select_mid_i, strap_select_low_i};
      strap_q <= strap_s0_q;
    end
  end

  assign scl_rise = scl_sq[1] && !scl_prev_q;
  assign scl_fall = !scl_sq[1] && scl_prev_q;
  assign start_det = scl_sq[1] && scl_prev_q && sda_prev_q && !sda_sq[1];
  assign stop_det = scl_sq[1] && scl_prev_q && !sda_prev_q && sda_sq[1];
  assign in_prog = state_q == seea_pkg::ST_PROG;
  assign byte_done = scl_fall && cnt_q == CNT_LAST;
  assign dev_match = shreg_q[7:4] == seea_pkg::DEV_TYPE &&
      ((shreg_q[3:1] ^ strap_q) & STRAP_MASK) == 3'h0;
  assign widx = addr_q[3:0] & PG_MASK[3:0];
  assign prog_done = in_prog && prog_idx_q == IDX_END && prog_cnt_q == PROG_LAST &&
      !wr_out.valid;

  // bus sequencer; all bus events are dropped while programming
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      state_q <= seea_pkg::ST_IDLE;
      cnt_q <= 4'h0;
      shreg_q <= 8'h00;
      rw_q <= 1'b0;
      sda_oe_q <= 1'b0;
      page_bits_q <= 3'h0;
    end else if (in_prog) begin
      sda_oe_q <= 1'b0;
      if (prog_done) begin
        state_q <= seea_pkg::ST_IDLE;
      end
    end else if (start_det) begin
      state_q <= seea_pkg::ST_DEVADR;
      cnt_q <= 4'h0;
      sda_oe_q <= 1'b0;
    end else if (stop_det) begin
      sda_oe_q <= 1'b0;
      state_q <= data_seen_q ? seea_pkg::ST_PROG : seea_pkg::ST_IDLE;
    end else begin
      unique case (state_q)
        seea_pkg::ST_IDLE: begin
        end
        seea_pkg::ST_DEVADR, seea_pkg::ST_WORD, seea_pkg::ST_WDATA: begin
          if (scl_rise) begin
            shreg_q <= {shreg_q[6:0], sda_sq[1]};
            cnt_q <= cnt_q + 4'h1;
          end else if (byte_done) begin
            cnt_q <= 4'h0;
            if (state_q == seea_pkg::ST_WORD) begin
              sda_oe_q <= 1'b1;
              state_q <= seea_pkg::ST_WORD_ACK;
            end else if (state_q == seea_pkg::ST_WDATA) begin
              sda_oe_q <= 1'b1;
              state_q <= seea_pkg::ST_WDATA_ACK;
            end else if (dev_match) begin
              sda_oe_q <= 1'b1;
              rw_q <= shreg_q[0];
              page_bits_q <= shreg_q[3:1] & ~STRAP_MASK;
              state_q <= seea_pkg::ST_ADR_ACK;
            end else begin
              state_q <= seea_pkg::ST_IDLE;
            end
          end
        end
        seea_pkg::ST_ADR_ACK, seea_pkg::ST_RD_LOAD: begin
          if (scl_fall) begin
            if (rw_q) begin
              shreg_q <= mem_rdata_i;
              sda_oe_q <= !mem_rdata_i[7];
              cnt_q <= 4'h1;
              state_q <= seea_pkg::ST_RDATA;
            end else begin
              sda_oe_q <= 1'b0;
              state_q <= seea_pkg::ST_WORD;
            end
          end
        end
        seea_pkg::ST_WORD_ACK, seea_pkg::ST_WDATA_ACK: begin
          if (scl_fall) begin
            sda_oe_q <= 1'b0;
            state_q <= seea_pkg::ST_WDATA;
          end
        end
        seea_pkg::ST_RDATA: begin
          if (byte_done) begin
            sda_oe_q <= 1'b0;
            cnt_q <= 4'h0;
            state_q <= seea_pkg::ST_RD_ACK;
          end else if (scl_fall) begin
            shreg_q <= {shreg_q[6:0], 1'b0};
            sda_oe_q <= !shreg_q[6];
            cnt_q <= cnt_q + 4'h1;
          end
        end
        seea_pkg::ST_RD_ACK: begin
          if (scl_rise) begin
            // a withheld acknowledge ends the read; stop is awaited in idle
            state_q <= sda_sq[1] ? seea_pkg::ST_IDLE : seea_pkg::ST_RD_LOAD;
          end
        end
        seea_pkg::ST_PROG: begin
        end
      endcase
    end
  end

  // word address counter survives between transfers
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      addr_q <= 11'h000;
    end else if (!in_prog && !start_det && !stop_det) begin
      if (state_q == seea_pkg::ST_WORD && byte_done) begin
        addr_q <= {page_bits_q, shreg_q} & ADDR_MASK;
      end else if (state_q == seea_pkg::ST_WDATA && byte_done) begin
        addr_q <= (addr_q & ~PG_MASK) | ((addr_q + 11'h001) & PG_MASK);
      end else if (state_q == seea_pkg::ST_RDATA && byte_done) begin
        addr_q <= (addr_q + 11'h001) & ADDR_MASK;
      end
    end
  end

  // page buffer; a new start before stop throws collected bytes away
  always_ff @(posedge clk_i) begin
    if (!in_prog && !start_det && !stop_det && state_q == seea_pkg::ST_WDATA && byte_done) begin
      buf_q[widx] <= shreg_q;
    end
  end

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      buf_vld_q <= '0;
      data_seen_q <= 1'b0;
      row_q <= 11'h000;
    end else if (prog_done || (start_det && !in_prog)) begin
      buf_vld_q <= '0;
      data_seen_q <= 1'b0;
    end else if (!in_prog && !stop_det && state_q == seea_pkg::ST_WDATA && byte_done) begin
      buf_vld_q[widx] <= 1'b1;
      data_seen_q <= 1'b1;
      row_q <= addr_q & ~PG_MASK;
    end
  end

  // programming: buffer drains through the fifo while the timer runs
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      prog_idx_q <= 5'h00;
      prog_cnt_q <= 32'h0;
    end else if (!in_prog) begin
      prog_idx_q <= 5'h00;
      prog_cnt_q <= 32'h0;
    end else begin
      if (prog_cnt_q != PROG_LAST) begin
        prog_cnt_q <= prog_cnt_q + 32'h1;
      end
      if (prog_idx_q != IDX_END && (!wr_in.valid || wr_in.ready)) begin
        prog_idx_q <= prog_idx_q + 5'h01;
      end
    end
  end

  assign wr_in.valid = in_prog && prog_idx_q != IDX_END && buf_vld_q[prog_idx_q[3:0]];
  assign wr_in.data = {row_q | {7'h00, prog_idx_q[3:0]}, buf_q[prog_idx_q[3:0]]};
  assign wr_out.ready = mem_wready_i;

  seea_fifo #(.W(seea_pkg::BUF_W), .DEPTH(seea_pkg::FIFO_DEPTH)) u_fifo (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .in_s(wr_in),
    .out_s(wr_out)
  );

  assign sda_o = 1'b0;
  assign sda_oe_o = sda_oe_q;
  assign mem_raddr_o = addr_q;
  assign mem_we_o = wr_out.valid;
  assign mem_waddr_o = wr_out.data[18:8];
  assign mem_wdata_o = wr_out.data[7:0];
  assign busy_o = in_prog;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);

  dev_nack_a: assert property (state_q == seea_pkg::ST_DEVADR && byte_done && !start_det &&
      !stop_det && !dev_match |=> state_q == seea_pkg::ST_IDLE && !sda_oe_o)
    else $error("unmatched device address was acknowledged");
  word_ack_a: assert property (state_q == seea_pkg::ST_WORD && byte_done && !start_det &&
      !stop_det |=> state_q == seea_pkg::ST_WORD_ACK && sda_oe_o)
    else $error("word address not acknowledged");
  data_ack_a: assert property (state_q == seea_pkg::ST_WDATA && byte_done && !start_det &&
      !stop_det |=> state_q == seea_pkg::ST_WDATA_ACK && sda_oe_o)
    else $error("data byte not acknowledged");
  prog_quiet_a: assert property ($past(in_prog) && in_prog |-> !sda_oe_o)
    else $error("bus driven during programming");
  page_wrap_a: assert property (state_q == seea_pkg::ST_WDATA && byte_done && !start_det &&
      !stop_det |=> (addr_q & ~PG_MASK) == ($past(addr_q) & ~PG_MASK))
    else $error("write address left its page");
  read_wrap_a: assert property (state_q == seea_pkg::ST_RDATA && byte_done && !start_det &&
      !stop_det && !in_prog && addr_q == ADDR_MASK |=> addr_q == 11'h000)
    else $error("read address did not wrap to zero");
  stop_noprog_a: assert property (stop_det && !in_prog && !start_det &&
      !data_seen_q |=> state_q == seea_pkg::ST_IDLE && $stable(addr_q))
    else $error("stop without data changed state or address");
  stop_prog_a: assert property (stop_det && !in_prog && !start_det &&
      data_seen_q |=> busy_o)
    else $error("stop after data did not start programming");
  prog_len_a: assert property ($fell(busy_o) |-> $past(prog_cnt_q) == PROG_LAST)
    else $error("programming ended before its time");
  rd_next_a: assert property (state_q == seea_pkg::ST_RD_ACK && scl_rise && !sda_sq[1] &&
      !start_det && !stop_det |=> state_q == seea_pkg::ST_RD_LOAD)
    else $error("host acknowledge did not continue the read");
  dir_bit_a: assert property (state_q == seea_pkg::ST_DEVADR && byte_done && dev_match &&
      !start_det && !stop_det && !in_prog |=> rw_q == $past(shreg_q[0]))
    else $error("direction bit not taken from eighth bit");

  page_write_c: cover property (state_q == seea_pkg::ST_WDATA_ACK ##1
      state_q == seea_pkg::ST_WDATA [*1] ##[1:1000] busy_o);
  seq_read_c: cover property (state_q == seea_pkg::ST_RD_LOAD ##[1:1000]
      state_q == seea_pkg::ST_RDATA);
  nack_c: cover property (state_q == seea_pkg::ST_DEVADR ##1 state_q == seea_pkg::ST_IDLE);
endmodule
`default_nettype wire

/* File: dv/seea_host_model.sv */
// bus host model: makes the bus clock and pulls the data line low
// assumes the bench resolves the open-drain data line with a pull-up
`timescale 1ns/1ps
`default_nettype none
module seea_host_model (
  input wire logic clk_i,  // system clock, paces the bus
  input wire logic sda_i,  // resolved data line
  output logic scl_o,      // bus clock, stands high between frames
  output logic sda_pull_o  // high while the host pulls data low
);
  initial begin
    scl_o = 1'h1;
    sda_pull_o = 1'h0;
  end
  // data moves a quarter period after the clock falls, so the device never
  // sees both lines change in the same synchroniser cycle
  task automatic quarter();
    repeat (4) @(negedge clk_i);
  endtask
  task automatic half();
    quarter();
    quarter();
  endtask
  // also serves as repeated start when the clock is low
  task automatic start_cond();
    quarter();
    sda_pull_o = 1'h0;
    quarter();
    scl_o = 1'h1;
    half();
    sda_pull_o = 1'h1;
    half();
    scl_o = 1'h0;
  endtask
  task automatic stop_cond();
    quarter();
    sda_pull_o = 1'h1;
    quarter();
    scl_o = 1'h1;
    half();
    sda_pull_o = 1'h0;
    half();
  endtask
  task automatic send_bit(input logic b, output logic r);
    quarter();
    sda_pull_o = !b;
    quarter();
    scl_o = 1'h1;
    half();
    r = sda_i;
    scl_o = 1'h0;
  endtask
  // byte msb first, then the acknowledge bit
  task automatic xfer(input logic [7:0] tx, input logic ack_tx, output logic [7:0] rx,
      output logic ack_rx);
    for (int i = 7; i >= 0; i--) begin
      send_bit(tx[i], rx[i]);
    end
    send_bit(ack_tx, ack_rx);
  endtask
endmodule
`default_nettype wire

/* File: dv/seea_engine_test.sv */
// self-checking bench of the eeprom command engine, 16K density
// assumes a host model on the bus and an array model with random write stalls
`timescale 1ns/1ps
`default_nettype none
module seea_engine_test;
  logic clk_i = 1'h0;
  logic sys_rst_i = 1'h1;
  logic scl, host_pull, sda_line, sda_o, sda_oe, busy, mem_we;
  logic mem_wready = 1'h0;
  logic [10:0] mem_raddr, mem_waddr, ref_addr;
  logic [7:0] mem_wdata, lf = 8'h4a, wlf = 8'h4a;
  logic [7:0] mem_rdata = 8'h00;
  logic [7:0] arr [2048];
  logic [7:0] ref_arr [2048];
  int failures = 0;
  int cmp_count = 0;
  always #5 clk_i = !clk_i;
  assign sda_line = !(host_pull || (sda_oe && !sda_o));
  seea_host_model host (.clk_i(clk_i), .sda_i(sda_line), .scl_o(scl), .sda_pull_o(host_pull));
  // long enough that a poll sent right after the stop lands inside programming
  seea_engine #(.PROG_CYCLES(400)) seea_engine_inst (
    .clk_i(clk_i), .sys_rst_i(sys_rst_i), .scl_i(scl), .sda_i(sda_line), .sda_o(sda_o),
    .sda_oe_o(sda_oe), .strap_select_high_i(1'h0), .strap_select_mid_i(1'h0),
    .strap_select_low_i(1'h0), .mem_raddr_o(mem_raddr), .mem_rdata_i(mem_rdata),
    .mem_waddr_o(mem_waddr), .mem_wdata_o(mem_wdata), .mem_we_o(mem_we),
    .mem_wready_i(mem_wready), .busy_o(busy));
  function automatic logic [7:0] lfsr_step(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  function automatic logic [7:0] rnd();
    lf = lfsr_step(lf);
    return lf;
  endfunction
  // 16-byte pages: only the low four address bits move during a write
  function automatic logic [10:0] page_next(input logic [10:0] a);
    return {a[10:4], a[3:0] + 4'h1};
  endfunction
  // reads run across the whole array and wrap at its end
  function automatic logic [10:0] read_next(input logic [10:0] a);
    return a + 11'h001;
  endfunction
  initial begin
    for (int i = 0; i < 2048; i++) begin
      arr[i] = i[7:0] ^ 8'h5a;
      ref_arr[i] = i[7:0] ^ 8'h5a;
    end
  end
  always @(posedge clk_i) begin
    mem_rdata <= arr[mem_raddr];
    if (mem_we && mem_wready) begin
      arr[mem_waddr] <= mem_wdata;
    end
  end
  always @(negedge clk_i) begin
    wlf <= lfsr_step(wlf);
    mem_wready <= wlf[0];
  end
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic check(input string what, input logic [10:0] seen, input logic [10:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      failures++;
      $display("FAIL %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic open_xfer(input logic [10:0] a, input logic rd, output logic ack);
    logic [7:0] rx;
    host.start_cond();
    host.xfer({seea_pkg::DEV_TYPE, a[10:8], rd}, 1'h1, rx, ack);
  endtask
  task automatic wait_idle();
    int n;
    n = 0;
    while (busy !== 1'h0 && n < 3000) begin
      @(negedge clk_i);
      n++;
    end
    if (n == 3000) begin
      failures++;
      complete_run();
    end
  endtask
  task automatic write_seq(input logic [10:0] a, input int n);
    logic ack;
    logic [7:0] rx, d;
    open_xfer(a, 1'h0, ack);
    check("dev ack", 11'(ack), 11'h0);
    host.xfer(a[7:0], 1'h1, rx, ack);
    check("word ack", 11'(ack), 11'h0);
    for (int i = 0; i < n; i++) begin
      d = rnd();
      host.xfer(d, 1'h1, rx, ack);
      check("data ack", 11'(ack), 11'h0);
      ref_arr[a] = d;
      a = page_next(a);
    end
    host.stop_cond();
    ref_addr = a;
  endtask
  task automatic read_bytes(input int n);
    logic ack;
    logic [7:0] rx;
    for (int i = 0; i < n; i++) begin
      host.xfer(8'hff, i == n - 1, rx, ack);
      check("read data", 11'(rx), 11'(ref_arr[ref_addr]));
      ref_addr = read_next(ref_addr);
    end
    host.stop_cond();
  endtask
  task automatic random_read(input logic [10:0] a, input int n);
    logic ack;
    logic [7:0] rx;
    open_xfer(a, 1'h0, ack);
    check("dummy dev ack", 11'(ack), 11'h0);
    host.xfer(a[7:0], 1'h1, rx, ack);
    check("dummy word ack", 11'(ack), 11'h0);
    open_xfer(a, 1'h1, ack);
    check("read dev ack", 11'(ack), 11'h0);
    ref_addr = a;
    read_bytes(n);
  endtask
  initial begin
    logic ack;
    logic [10:0] a;
    logic [7:0] r;
    repeat (4) @(negedge clk_i);
    sys_rst_i = 1'h0;
    repeat (8) @(negedge clk_i);
    r = rnd();
    a = {r[2:0], rnd()};
    write_seq(a, 1);
    check("busy after stop", 11'(busy), 11'h1);
    open_xfer(a, 1'h0, ack);
    check("poll while busy", 11'(ack), 11'h1);
    host.stop_cond();
    wait_idle();
    random_read(a, 1);
    $display("test byte write and polling done");
    r = rnd();
    a = {r[2:0], rnd()};
    a[3:0] = 4'he;
    // 18 bytes from offset 14 wrap and overwrite the first two
    write_seq(a, 18);
    wait_idle();
    random_read({a[10:4], 4'h0}, 16);
    $display("test page write wrap done");
    random_read(11'h7fe, 4);
    open_xfer(ref_addr, 1'h1, ack);
    check("current read ack", 11'(ack), 11'h0);
    read_bytes(2);
    $display("test read wrap and current read done");
    host.start_cond();
    host.xfer({4'hb, 3'h0, 1'h0}, 1'h1, r, ack);
    check("foreign type ack", 11'(ack), 11'h1);
    host.stop_cond();
    a = {3'h2, rnd()};
    write_seq(a, 0);
    check("busy after word only", 11'(busy), 11'h0);
    open_xfer(ref_addr, 1'h1, ack);
    check("loaded read ack", 11'(ack), 11'h0);
    read_bytes(1);
    $display("test mismatch and address load done");
    complete_run();
  end
endmodule
`default_nettype wire
